//--- hdl/cas_defines.svh
// Constants for the addressing and special-operation core
// Notes on behaviour
// - Immediate operand bytes are data; opcode picks width
// - Vector n reads FFC0+2n high, FFC1+2n low
// - Vector number is three bits, eight entries
// - Relative branch adds signed byte to counter
// - Inherent opcodes have no operands, opcode-defined action
// - Jump via accumulator loads counter from accumulator
// - Counter copy gives next opcode address
// - Multiply low bytes, 16-bit product, temp kept
// - Multiply and divide leave flags untouched
// - Divide temp by low acc; quotient, remainder, highs zero
// - Quotient overflow gives unpredictable result, no flag
// - Exchange swaps accumulator and next-opcode counter
// - Vectored call pushes return address, jumps via table
// - Vectored call is one byte, number inside opcode
// - Bit ops read byte, change one bit, write back
// - Bit position from low three opcode bits
// - Bit op: four bus cycles, strobes active low
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define CAS_OP_MOV_IMM8 8'h04
`define CAS_OP_MOVW_IMM16 8'hE4
`define CAS_OP_MOVW_SP_IMM 8'hE5
`define CAS_OP_BZ 8'hFD
`define CAS_OP_MULU 8'h01
`define CAS_OP_DIVU 8'h11
`define CAS_OP_PC_TO_A 8'hF0
`define CAS_OP_JUMP_VIA_ACCUMULATOR 8'hE0
`define CAS_OP_XCH_PC 8'hF4
`define CAS_OP_CALLV_BASE 5'h1D
`define CAS_OP_BIT_BASE 4'hA

// ****************************************************************
// Fields, addresses, resets and timing
// ****************************************************************
`define CAS_OP_SET_BIT 3
`define CAS_VEC_BASE 16'hFFC0
`define CAS_DIRECT_PAGE 8'h00
`define CAS_PC_RESET 16'h0000
`define CAS_SP_RESET 16'h0200
`define CAS_MD_STEPS 4'h8
`define CAS_MULU_CYCLES 5'h13
`define CAS_DIVU_CYCLES 5'h15

`endif

//--- hdl/cas_pkg.sv
// Types shared by the addressing and special-operation core
package cas_pkg;

	typedef enum logic [3:0] {
		ST_FETCH = 4'h0,
		ST_OP1 = 4'h1,
		ST_OP2 = 4'h3,
		ST_INH = 4'h2,
		ST_RMW_RD = 4'h6,
		ST_RMW_WR = 4'h7,
		ST_STK_HI = 4'h5,
		ST_STK_LO = 4'h4,
		ST_VEC_HI = 4'hC,
		ST_VEC_LO = 4'hD,
		ST_MD_WAIT = 4'hF
	} cas_state_t;

	typedef enum logic [3:0] {
		CL_NOP = 4'h0,
		CL_IMM8 = 4'h1,
		CL_IMM16 = 4'h2,
		CL_SP_IMM = 4'h3,
		CL_BZ = 4'h4,
		CL_JUMP_VIA_ACCUMULATOR = 4'h5,
		CL_PC_TO_A = 4'h6,
		CL_XCH_PC = 4'h7,
		CL_MULU = 4'h8,
		CL_DIVU = 4'h9,
		CL_CALLV = 4'hA,
		CL_BIT = 4'hB
	} cas_class_t;

endpackage

//--- hdl/cas_decode.sv
// Opcode classifier for the core
`timescale 1ns/1ps
`include "cas_defines.svh"

module cas_decode (
	input wire logic [7:0] opcode_in,
	output cas_pkg::cas_class_t class_out,
	output logic [2:0] field_out,
	output logic bit_set_out
);

	always_comb begin
		field_out = opcode_in[2:0];
		bit_set_out = opcode_in[`CAS_OP_SET_BIT];
		if (opcode_in[7:3] == `CAS_OP_CALLV_BASE) begin
			class_out = cas_pkg::CL_CALLV;
		end else if (opcode_in[7:4] == `CAS_OP_BIT_BASE) begin
			class_out = cas_pkg::CL_BIT;
		end else begin
			case (opcode_in)
				`CAS_OP_MOV_IMM8: class_out = cas_pkg::CL_IMM8;
				`CAS_OP_MOVW_IMM16: class_out = cas_pkg::CL_IMM16;
				`CAS_OP_MOVW_SP_IMM: class_out = cas_pkg::CL_SP_IMM;
				`CAS_OP_BZ: class_out = cas_pkg::CL_BZ;
				`CAS_OP_MULU: class_out = cas_pkg::CL_MULU;
				`CAS_OP_DIVU: class_out = cas_pkg::CL_DIVU;
				`CAS_OP_PC_TO_A: class_out = cas_pkg::CL_PC_TO_A;
				`CAS_OP_JUMP_VIA_ACCUMULATOR: class_out = cas_pkg::CL_JUMP_VIA_ACCUMULATOR;
				`CAS_OP_XCH_PC: class_out = cas_pkg::CL_XCH_PC;
				default: class_out = cas_pkg::CL_NOP;
			endcase
		end
	end

endmodule // cas_decode

//--- hdl/cas_muldiv.sv
// Iterative unsigned 8x8 multiply and 16/8 divide
`timescale 1ns/1ps
`include "cas_defines.svh"

module cas_muldiv (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic div_in,
	input wire logic [15:0] acc_in,
	input wire logic [15:0] temp_in,
	output logic done_out,
	output logic [15:0] acc_res_out,
	output logic [15:0] temp_res_out
);

	logic [3:0] step_q;
	logic busy_q;
	logic div_q;
	logic [7:0] opnd_q;
	logic [16:0] work_q;
	logic [7:0] quot_q;
	logic [8:0] trial;
	logic [16:0] addsum;

	always_comb begin
		trial = {work_q[7:0], quot_q[7]} - {1'b0, opnd_q};
		addsum = {1'b0, work_q[15:8] + (work_q[0] ? opnd_q : 8'h00), work_q[7:0]};
		if (work_q[0]) begin
			addsum[16:8] = {1'b0, work_q[15:8]} + {1'b0, opnd_q};
		end
	end

	// ****************************************************************
	// Sequencing
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			step_q <= 4'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= busy_q && (step_q == `CAS_MD_STEPS - 4'h1);
			if (start_in) begin
				busy_q <= 1'b1;
				step_q <= 4'h0;
			end else if (busy_q) begin
				step_q <= step_q + 4'h1;
				busy_q <= step_q != `CAS_MD_STEPS - 4'h1;
			end
		end
	end

	// ****************************************************************
	// Datapath
	// ****************************************************************
	// Divide keeps an 8-bit partial remainder in work_q[7:0] plus the
	// trial borrow; the high byte of the dividend is preloaded there and the
	// low byte into quot_q, so a quotient wider than eight bits is silently lost.
	always_ff @(posedge clk_in) begin
		if (start_in) begin
			div_q <= div_in;
			opnd_q <= div_in ? acc_in[7:0] : temp_in[7:0];
			work_q <= div_in ? {9'h000, temp_in[15:8]} : {9'h000, acc_in[7:0]};
			quot_q <= temp_in[7:0];
		end else if (busy_q) begin
			if (div_q) begin
				if (!trial[8] || work_q[7]) begin
					work_q <= {9'h000, trial[7:0]};
				end else begin
					work_q <= {9'h000, work_q[6:0], quot_q[7]};
				end
				quot_q <= {quot_q[6:0], (!trial[8] || work_q[7])};
			end else begin
				work_q <= {1'b0, addsum[16:1]};
			end
		end
	end

	always_comb begin
		if (div_q) begin
			acc_res_out = {8'h00, quot_q};
			temp_res_out = {8'h00, work_q[7:0]};
		end else begin
			acc_res_out = work_q[15:0];
			temp_res_out = 16'h0000;
		end
	end

endmodule // cas_muldiv

//--- hdl/cas_core.sv
// Execution core: immediate, vector, relative, inherent and special operations
`timescale 1ns/1ps
`include "cas_defines.svh"

module cas_core (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] DATA_IN,
	output logic [15:0] ADDR_OUT,
	output logic [7:0] DATA_OUT,
	output logic RD_N_OUT,
	output logic WR_N_OUT,
	output logic RMW_OUT,
	output logic [15:0] ACC_OUT,
	output logic [15:0] TEMP_OUT,
	output logic [15:0] PC_OUT,
	output logic [15:0] SP_OUT,
	output logic FLAG_N_OUT,
	output logic FLAG_Z_OUT
);

	cas_pkg::cas_state_t state_q;
	cas_pkg::cas_class_t class_q;
	cas_pkg::cas_class_t dec_class;
	logic [7:0] opcode_q;
	logic [15:0] program_counter_q;
	logic [15:0] stack_pointer_q;
	logic [15:0] acc_q;
	logic [15:0] temp_q;
	logic flag_n_q;
	logic flag_z_q;
	logic [7:0] oper_lo_q;
	logic [7:0] rmw_data_q;
	logic [7:0] vec_hi_q;
	logic [4:0] wait_q;
	logic [2:0] dec_field;
	logic dec_set;
	logic md_start;
	logic [15:0] md_acc;
	logic [15:0] md_temp;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] vec_addr(input logic [2:0] num, input logic low);
		vec_addr = `CAS_VEC_BASE + {12'h000, num, low};
	endfunction

	function automatic logic [7:0] bit_mod(input logic [7:0] data, input logic [2:0] pos, input logic set);
		logic [7:0] mask;
		mask = 8'h01 << pos;
		bit_mod = set ? (data | mask) : (data & ~mask);
	endfunction

	cas_decode u_decode (
		.opcode_in(DATA_IN),
		.class_out(dec_class),
		.field_out(),
		.bit_set_out()
	);

	cas_decode u_field (
		.opcode_in(opcode_q),
		.class_out(),
		.field_out(dec_field),
		.bit_set_out(dec_set)
	);

	assign md_start = (state_q == cas_pkg::ST_FETCH)
		&& (dec_class == cas_pkg::CL_MULU || dec_class == cas_pkg::CL_DIVU);

	cas_muldiv u_muldiv (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.start_in(md_start),
		.div_in(dec_class == cas_pkg::CL_DIVU),
		.acc_in(acc_q),
		.temp_in(temp_q),
		.done_out(),
		.acc_res_out(md_acc),
		.temp_res_out(md_temp)
	);

	// ****************************************************************
	// Bus drive
	// ****************************************************************
	// All bus outputs decode flops only, so no input reaches them combinationally
	always_comb begin
		ADDR_OUT = program_counter_q;
		DATA_OUT = 8'h00;
		RD_N_OUT = 1'b1;
		WR_N_OUT = 1'b1;
		RMW_OUT = 1'b0;
		case (state_q)
			cas_pkg::ST_FETCH, cas_pkg::ST_OP1, cas_pkg::ST_OP2: begin
				RD_N_OUT = 1'b0;
			end
			cas_pkg::ST_RMW_RD: begin
				ADDR_OUT = {`CAS_DIRECT_PAGE, oper_lo_q};
				RD_N_OUT = 1'b0;
				RMW_OUT = 1'b1;
			end
			cas_pkg::ST_RMW_WR: begin
				ADDR_OUT = {`CAS_DIRECT_PAGE, oper_lo_q};
				DATA_OUT = rmw_data_q;
				WR_N_OUT = 1'b0;
			end
			cas_pkg::ST_STK_HI: begin
				ADDR_OUT = stack_pointer_q - 16'h0002;
				DATA_OUT = program_counter_q[15:8];
				WR_N_OUT = 1'b0;
			end
			cas_pkg::ST_STK_LO: begin
				ADDR_OUT = stack_pointer_q + 16'h0001;
				DATA_OUT = program_counter_q[7:0];
				WR_N_OUT = 1'b0;
			end
			cas_pkg::ST_VEC_HI: begin
				ADDR_OUT = vec_addr(dec_field, 1'b0);
				RD_N_OUT = 1'b0;
			end
			cas_pkg::ST_VEC_LO: begin
				ADDR_OUT = vec_addr(dec_field, 1'b1);
				RD_N_OUT = 1'b0;
			end
			default: begin
				ADDR_OUT = program_counter_q;
			end
		endcase
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			state_q <= cas_pkg::ST_FETCH;
			class_q <= cas_pkg::CL_NOP;
			opcode_q <= 8'h00;
			wait_q <= 5'h00;
		end else begin
			case (state_q)
				cas_pkg::ST_FETCH: begin
					opcode_q <= DATA_IN;
					class_q <= dec_class;
					case (dec_class)
						cas_pkg::CL_IMM8, cas_pkg::CL_IMM16, cas_pkg::CL_SP_IMM,
						cas_pkg::CL_BZ, cas_pkg::CL_BIT: begin
							state_q <= cas_pkg::ST_OP1;
						end
						cas_pkg::CL_CALLV: begin
							state_q <= cas_pkg::ST_STK_HI;
						end
						cas_pkg::CL_MULU: begin
							wait_q <= `CAS_MULU_CYCLES - 5'h02;
							state_q <= cas_pkg::ST_MD_WAIT;
						end
						cas_pkg::CL_DIVU: begin
							wait_q <= `CAS_DIVU_CYCLES - 5'h02;
							state_q <= cas_pkg::ST_MD_WAIT;
						end
						default: begin
							state_q <= cas_pkg::ST_INH;
						end
					endcase
				end
				cas_pkg::ST_OP1: begin
					if (class_q == cas_pkg::CL_BIT) begin
						state_q <= cas_pkg::ST_RMW_RD;
					end else if (class_q == cas_pkg::CL_IMM8 || class_q == cas_pkg::CL_BZ) begin
						state_q <= cas_pkg::ST_FETCH;
					end else begin
						state_q <= cas_pkg::ST_OP2;
					end
				end
				cas_pkg::ST_RMW_RD: state_q <= cas_pkg::ST_RMW_WR;
				cas_pkg::ST_STK_HI: state_q <= cas_pkg::ST_STK_LO;
				cas_pkg::ST_STK_LO: state_q <= cas_pkg::ST_VEC_HI;
				cas_pkg::ST_VEC_HI: state_q <= cas_pkg::ST_VEC_LO;
				cas_pkg::ST_MD_WAIT: begin
					wait_q <= wait_q - 5'h01;
					if (wait_q == 5'h00) begin
						state_q <= cas_pkg::ST_FETCH;
					end
				end
				default: begin
					state_q <= cas_pkg::ST_FETCH;
				end
			endcase
		end
	end

	// ****************************************************************
	// Program counter
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			program_counter_q <= `CAS_PC_RESET;
		end else begin
			case (state_q)
				cas_pkg::ST_FETCH, cas_pkg::ST_OP2: begin
					program_counter_q <= program_counter_q + 16'h0001;
				end
				cas_pkg::ST_OP1: begin
					if (class_q == cas_pkg::CL_BZ && flag_z_q) begin
						// Offset is taken from the address past the operand
						program_counter_q <= program_counter_q + 16'h0001
							+ {{8{DATA_IN[7]}}, DATA_IN};
					end else begin
						program_counter_q <= program_counter_q + 16'h0001;
					end
				end
				cas_pkg::ST_INH: begin
					if (class_q == cas_pkg::CL_JUMP_VIA_ACCUMULATOR || class_q == cas_pkg::CL_XCH_PC) begin
						program_counter_q <= acc_q;
					end
				end
				cas_pkg::ST_VEC_LO: begin
					program_counter_q <= {vec_hi_q, DATA_IN};
				end
				default: begin
					program_counter_q <= program_counter_q;
				end
			endcase
		end
	end

	// ****************************************************************
	// Stack pointer and vector capture
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			stack_pointer_q <= `CAS_SP_RESET;
			vec_hi_q <= 8'h00;
		end else begin
			if (state_q == cas_pkg::ST_STK_HI) begin
				stack_pointer_q <= stack_pointer_q - 16'h0002;
			end else if (state_q == cas_pkg::ST_OP2 && class_q == cas_pkg::CL_SP_IMM) begin
				stack_pointer_q <= {oper_lo_q, DATA_IN};
			end
			if (state_q == cas_pkg::ST_VEC_HI) begin
				vec_hi_q <= DATA_IN;
			end
		end
	end

	// ****************************************************************
	// Operand and modify data
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			oper_lo_q <= 8'h00;
			rmw_data_q <= 8'h00;
		end else begin
			if (state_q == cas_pkg::ST_OP1) begin
				oper_lo_q <= DATA_IN;
			end
			if (state_q == cas_pkg::ST_RMW_RD) begin
				rmw_data_q <= bit_mod(DATA_IN, dec_field, dec_set);
			end
		end
	end

	// ****************************************************************
	// Accumulators and flags
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			acc_q <= 16'h0000;
			temp_q <= 16'h0000;
			flag_n_q <= 1'b0;
			flag_z_q <= 1'b0;
		end else begin
			case (state_q)
				cas_pkg::ST_OP1: begin
					if (class_q == cas_pkg::CL_IMM8) begin
						temp_q <= {temp_q[15:8], acc_q[7:0]};
						acc_q <= {acc_q[15:8], DATA_IN};
						flag_n_q <= DATA_IN[7];
						flag_z_q <= DATA_IN == 8'h00;
					end
				end
				cas_pkg::ST_OP2: begin
					if (class_q == cas_pkg::CL_IMM16) begin
						temp_q <= acc_q;
						acc_q <= {oper_lo_q, DATA_IN};
						flag_n_q <= oper_lo_q[7];
						flag_z_q <= {oper_lo_q, DATA_IN} == 16'h0000;
					end
				end
				cas_pkg::ST_INH: begin
					if (class_q == cas_pkg::CL_PC_TO_A || class_q == cas_pkg::CL_XCH_PC) begin
						acc_q <= program_counter_q;
					end
				end
				cas_pkg::ST_MD_WAIT: begin
					// Flags are deliberately left alone here
					if (wait_q == 5'h00) begin
						acc_q <= md_acc;
						if (class_q == cas_pkg::CL_DIVU) begin
							temp_q <= md_temp;
						end
					end
				end
				default: begin
					acc_q <= acc_q;
				end
			endcase
		end
	end

	assign ACC_OUT = acc_q;
	assign TEMP_OUT = temp_q;
	assign PC_OUT = program_counter_q;
	assign SP_OUT = stack_pointer_q;
	assign FLAG_N_OUT = flag_n_q;
	assign FLAG_Z_OUT = flag_z_q;

endmodule // cas_core

//--- testbench/cas_core_chk.sv
// Assertions on the bus sequences of the core
`timescale 1ns/1ps
module cas_core_chk (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] DATA_IN,
	input wire logic [15:0] ADDR_OUT,
	input wire logic [7:0] DATA_OUT,
	input wire logic RD_N_OUT,
	input wire logic WR_N_OUT,
	input wire logic RMW_OUT,
	input wire logic [15:0] ACC_OUT,
	input wire logic [15:0] TEMP_OUT,
	input wire logic [15:0] PC_OUT,
	input wire logic [15:0] SP_OUT,
	input wire logic FLAG_N_OUT,
	input wire logic FLAG_Z_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	// ****************************************************************
	// Properties
	// ****************************************************************
	function automatic logic [7:0] modify_bit(input logic [7:0] v, input logic [7:0] op);
		return op[3] ? (v | (8'h01 << op[2:0])) : (v & ~(8'h01 << op[2:0]));
	endfunction

	chk_strobes_apart: assert property (RD_N_OUT || WR_N_OUT)
		else $error("read and write strobes low together");
	chk_rmw_is_read: assert property (RMW_OUT |-> !RD_N_OUT && WR_N_OUT && !$past(RD_N_OUT))
		else $error("modify flag outside a read after operand fetch");
	chk_rmw_direct_page: assert property (RMW_OUT |-> ADDR_OUT == {8'h00, $past(DATA_IN)})
		else $error("modify read not at direct address");
	chk_rmw_write_back: assert property (RMW_OUT |=> !WR_N_OUT && !RMW_OUT && ADDR_OUT == $past(ADDR_OUT))
		else $error("write back missing or at another address");
	chk_bit_modified: assert property ($past(RMW_OUT) && !WR_N_OUT |-> DATA_OUT == modify_bit($past(DATA_IN), $past(DATA_IN, 3)))
		else $error("written byte differs from one-bit change");
	chk_bit_next_fetch: assert property (RMW_OUT |-> ##2 (!RD_N_OUT && ADDR_OUT == $past(ADDR_OUT, 3) + 16'h0001))
		else $error("fetch after bit op not at N+2");
	chk_vector_entry: assert property (!RD_N_OUT && ADDR_OUT[15:4] == 12'hFFC && !ADDR_OUT[0] && !$past(WR_N_OUT)
		|-> ADDR_OUT[3:1] == $past(DATA_IN[2:0], 3) ##1 (!RD_N_OUT && ADDR_OUT == $past(ADDR_OUT) + 16'h0001))
		else $error("vector table read at wrong entry");
	chk_call_push: assert property (!WR_N_OUT && !$past(WR_N_OUT) |-> ADDR_OUT == $past(ADDR_OUT) + 16'h0001
		&& {$past(DATA_OUT), DATA_OUT} == $past(ADDR_OUT, 2) + 16'h0001 ##2 SP_OUT == $past(ADDR_OUT, 3))
		else $error("return address push wrong");
	chk_flags_only_loads: assert property ($changed(FLAG_N_OUT) || $changed(FLAG_Z_OUT) |-> !$past(RD_N_OUT))
		else $error("flags changed without a load");
endmodule // cas_core_chk

bind cas_core cas_core_chk i_cas_core_chk (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .DATA_IN(DATA_IN),
	.ADDR_OUT(ADDR_OUT), .DATA_OUT(DATA_OUT), .RD_N_OUT(RD_N_OUT), .WR_N_OUT(WR_N_OUT), .RMW_OUT(RMW_OUT),
	.ACC_OUT(ACC_OUT), .TEMP_OUT(TEMP_OUT), .PC_OUT(PC_OUT), .SP_OUT(SP_OUT), .FLAG_N_OUT(FLAG_N_OUT),
	.FLAG_Z_OUT(FLAG_Z_OUT));

//--- testbench/cas_mem_model.sv
// Zero-wait memory with one port register and one interrupt flag register
`timescale 1ns/1ps
module cas_mem_model #(
	parameter logic [15:0] PORT_ADDR = 16'h0010,
	parameter logic [15:0] FLAG_ADDR = 16'h0020
) (
	input wire logic clk_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic rmw_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out
);
	logic [7:0] mem [0:65535];
	logic [7:0] port_latch_q;
	logic [7:0] port_pins;
	logic [7:0] irq_flags_q;
	logic [7:0] held_q = 8'h00;
	logic [7:0] rd_val;

	// ****************************************************************
	// Read and write paths
	// ****************************************************************
	always_comb begin
		if (addr_in == PORT_ADDR) rd_val = rmw_in ? port_latch_q : port_pins;
		else if (addr_in == FLAG_ADDR) rd_val = rmw_in ? 8'hFF : irq_flags_q;
		else rd_val = mem[addr_in];
		// Released bus shows the inverse so a late sample never looks valid
		data_out = rd_n_in ? ~held_q : rd_val;
	end

	always @(posedge clk_in) begin
		if (!rd_n_in) held_q <= rd_val;
		if (!wr_n_in) begin
			if (addr_in == PORT_ADDR) port_latch_q <= data_in;
			else if (addr_in == FLAG_ADDR) irq_flags_q <= irq_flags_q & data_in;
			else mem[addr_in] <= data_in;
		end
	end
endmodule // cas_mem_model

//--- testbench/testbench.sv
// Self-checking bench for the core with a memory and peripheral model
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module testbench;
	logic CLOCK_IN;
	logic RST_IN;
	logic [7:0] DATA_IN, DATA_OUT;
	logic [15:0] ADDR_OUT, ACC_OUT, TEMP_OUT, PC_OUT, SP_OUT;
	logic RD_N_OUT, WR_N_OUT, RMW_OUT, FLAG_N_OUT, FLAG_Z_OUT;
	int fail_count = 0;
	int comparisons = 0;
	int n;

	cas_core i_cas_core (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .DATA_IN(DATA_IN), .ADDR_OUT(ADDR_OUT),
		.DATA_OUT(DATA_OUT), .RD_N_OUT(RD_N_OUT), .WR_N_OUT(WR_N_OUT), .RMW_OUT(RMW_OUT), .ACC_OUT(ACC_OUT),
		.TEMP_OUT(TEMP_OUT), .PC_OUT(PC_OUT), .SP_OUT(SP_OUT), .FLAG_N_OUT(FLAG_N_OUT), .FLAG_Z_OUT(FLAG_Z_OUT));
	cas_mem_model i_cas_mem_model (.clk_in(CLOCK_IN), .rd_n_in(RD_N_OUT), .wr_n_in(WR_N_OUT), .rmw_in(RMW_OUT),
		.addr_in(ADDR_OUT), .data_in(DATA_OUT), .data_out(DATA_IN));

	initial begin
		CLOCK_IN = 1'b0;
		forever #2.5 CLOCK_IN = ~CLOCK_IN;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Each scenario starts from reset and a wiped memory
	task automatic begin_run();
		@(negedge CLOCK_IN);
		RST_IN = 1'b1;
		for (int i = 0; i < 65536; i++) i_cas_mem_model.mem[i] = 8'h00;
		repeat (6) @(negedge CLOCK_IN);
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] b [$]);
		foreach (b[i]) i_cas_mem_model.mem[a + 16'(i)] = b[i];
	endtask

	// Releases reset and counts cycles until the opcode fetch at a
	task automatic run_to(input logic [15:0] a);
		RST_IN = 1'b0;
		n = 0;
		do begin
			@(negedge CLOCK_IN);
			n++;
		end while (!(ADDR_OUT === a && RD_N_OUT === 1'b0) && n < 300);
		if (n >= 300) begin
			fail_count++;
			$display("[ERR] %0t no fetch at %h", $time, a);
			print_verdict();
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_immediate();
		begin_run();
		prog(16'h0000, '{8'h04, 8'h80, 8'hE4, 8'h12, 8'h34, 8'hF0});
		run_to(16'h0002);
		`CHECK(ACC_OUT[7:0], 8'h80)
		`CHECK(FLAG_N_OUT, 1'b1)
		run_to(16'h0005);
		`CHECK(n, 3)
		`CHECK(ACC_OUT, 16'h1234)
		`CHECK(TEMP_OUT[7:0], 8'h80)
		run_to(16'h0006);
		`CHECK(n, 2)
		`CHECK(ACC_OUT, 16'h0006)
	endtask

	task automatic t_jump();
		begin_run();
		prog(16'h0000, '{8'hE4, 8'h01, 8'h00, 8'hF4});
		prog(16'h0100, '{8'hE0});
		run_to(16'h0003);
		run_to(16'h0100);
		`CHECK(n, 2)
		`CHECK(ACC_OUT, 16'h0004)
		run_to(16'h0004);
		`CHECK(n, 2)
		@(negedge CLOCK_IN);
		`CHECK(PC_OUT, 16'h0005)
	endtask

	task automatic t_branch();
		begin_run();
		prog(16'h0000, '{8'h04, 8'h00, 8'hFD, 8'h10});
		prog(16'h0014, '{8'hFD, 8'hF0});
		prog(16'h0006, '{8'h04, 8'h01, 8'hFD, 8'h40});
		run_to(16'h0002);
		run_to(16'h0014);
		`CHECK(n, 2)
		run_to(16'h0006);
		`CHECK(n, 2)
		run_to(16'h0008);
		run_to(16'h000A);
		`CHECK(n, 2)
	endtask

	task automatic t_muldiv();
		begin_run();
		prog(16'h0000, '{8'hE4, 8'h34, 8'h56, 8'hE4, 8'hAB, 8'h07, 8'h01, 8'h11});
		run_to(16'h0003);
		run_to(16'h0006);
		run_to(16'h0007);
		`CHECK(n, 19)
		`CHECK(ACC_OUT, 16'h025A)
		`CHECK(TEMP_OUT, 16'h3456)
		`CHECK({FLAG_N_OUT, FLAG_Z_OUT}, 2'b10)
		run_to(16'h0008);
		`CHECK(n, 21)
		`CHECK(ACC_OUT, 16'h0094)
		`CHECK(TEMP_OUT, 16'h004E)
		`CHECK({FLAG_N_OUT, FLAG_Z_OUT}, 2'b10)
	endtask

	task automatic t_callv();
		begin_run();
		prog(16'h0000, '{8'hE5, 8'h03, 8'h00, 8'hEB});
		prog(16'hFFC6, '{8'h12, 8'h34});
		prog(16'h1234, '{8'hEF});
		prog(16'hFFCE, '{8'h56, 8'h78});
		run_to(16'h0003);
		run_to(16'h1234);
		`CHECK(n, 5)
		`CHECK(SP_OUT, 16'h02FE)
		`CHECK({i_cas_mem_model.mem[16'h02FE], i_cas_mem_model.mem[16'h02FF]}, 16'h0004)
		run_to(16'h5678);
		`CHECK(SP_OUT, 16'h02FC)
		`CHECK({i_cas_mem_model.mem[16'h02FC], i_cas_mem_model.mem[16'h02FD]}, 16'h1235)
	endtask

	task automatic t_bitops();
		begin_run();
		prog(16'h0000, '{8'hAB, 8'h40, 8'hA0, 8'h10, 8'hA0, 8'h20, 8'hAF, 8'h41});
		prog(16'h0040, '{8'h81});
		i_cas_mem_model.port_latch_q = 8'h0F;
		i_cas_mem_model.port_pins = 8'h00;
		i_cas_mem_model.irq_flags_q = 8'h05;
		run_to(16'h0002);
		`CHECK(n, 4)
		`CHECK(i_cas_mem_model.mem[16'h0040], 8'h89)
		run_to(16'h0004);
		`CHECK(i_cas_mem_model.port_latch_q, 8'h0E)
		run_to(16'h0006);
		`CHECK(i_cas_mem_model.irq_flags_q, 8'h04)
		run_to(16'h0008);
		`CHECK(n, 4)
		`CHECK(i_cas_mem_model.mem[16'h0041], 8'h80)
	endtask

	initial begin
		RST_IN = 1'b1;
		t_immediate();
		t_jump();
		t_branch();
		t_muldiv();
		t_callv();
		t_bitops();
		print_verdict();
	end
endmodule // testbench
